// ==== hdl/gew_edge_wake.sv ====
// Top: per-pin edge detection, pin interrupts, filtered wake-up, AXI4-Lite registers
// Functional notes
// - Rising edges detected on enabled pins
// - Rising status sticky until enable written zero
// - Per-pin falling enable arms falling detection
// - Falling status sticky until enable written zero
// - Set status requests pin interrupt when enabled
// - Pins route to interrupt A, B, or both
// - Enabled edge interrupt also signals wake-up
// - Four-bit source selects one of sixteen pins
// - Wake trigger on rising, falling, or both
// - Noise filter rejects short wake pulses
// - Filter time 1, 2, 4 or 8 ms
// - Filtered rise sets sticky rising wake flag
// - Filtered fall sets sticky falling wake flag
// - All configuration and flags reset to zero
//
// Local design decision: register access over AXI4-Lite.
module gew_edge_wake #(
  parameter int ADDR_W = 20,
  parameter int FILT_BASE_CYC = gew_pkg::FILT_BASE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins of port 0 and port 1
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  // Event outputs
  output logic pin_irq_a,
  output logic pin_irq_b,
  output logic wake_out,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import gew_pkg::*;

  // Refuse sizes the decode or the filter counter cannot serve
  if (ADDR_W < 20 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 20 to 32");
  end
  if (FILT_BASE_CYC < 1 || longint'(FILT_BASE_CYC) * 8 >= (longint'(1) << FILT_CNT_W)) begin : g_bad_filt
    $error("FILT_BASE_CYC out of range for filter counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0] pins;
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] sync3;
  logic [15:0] stable;
  logic [15:0] rise_evt;
  logic [15:0] fall_evt;
  logic [15:0] rise_en;
  logic [15:0] fall_en;
  logic [15:0] rise_status;
  logic [15:0] fall_status;
  logic [15:0] irq_a_sel;
  logic [15:0] irq_b_sel;
  logic [15:0] rise_clr;
  logic [15:0] fall_clr;
  logic wake_rise_enable;
  logic wake_fall_enable;
  logic wake_rise_flag;
  logic wake_fall_flag;
  logic [1:0] filter_time_sel;
  logic [3:0] wake_source_sel;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_full;
  logic [7:0] w_byte;
  logic w_lane;
  logic w_full;
  logic wr_go;
  logic wr_ok;
  logic [17:0] wr_idx;
  logic [17:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_hit;
  logic we_p0r;
  logic we_p1r;
  logic we_p0f;
  logic we_p1f;
  logic we_cfg;
  logic we_p0a;
  logic we_p0b;
  logic we_p1a;
  logic we_p1b;
  logic next_irq_a;
  logic next_irq_b;

  gew_wake_if wif ();
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  assign pins = {port1_in, port0_in};
  // Three stages per pin; a change counts once stages two and three agree
  genvar gi;
  for (gi = 0; gi < 16; gi++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1[gi] <= 1'b0;
        sync2[gi] <= 1'b0;
        sync3[gi] <= 1'b0;
        stable[gi] <= 1'b0;
      end else begin
        sync1[gi] <= pins[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        if (sync2[gi] == sync3[gi]) begin
          stable[gi] <= sync3[gi];
        end
      end
    end
    assign rise_evt[gi] = (sync2[gi] == sync3[gi]) && sync3[gi] && !stable[gi];
    assign fall_evt[gi] = (sync2[gi] == sync3[gi]) && !sync3[gi] && stable[gi];
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels
  // Address and data are taken in either order and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_byte <= REG_RESET;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write decode; unmapped or misaligned words answer SLVERR
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = aw_addr[19:2];
  assign wr_ok = (aw_addr[1:0] == 2'h0) && (aw_addr[ADDR_W-1:2] == (ADDR_W-2)'(wr_idx))
    && (wr_idx inside {IDX_P0_RISE, IDX_P1_RISE, IDX_WAKE_CFG, IDX_P0_FALL, IDX_P1_FALL,
                       IDX_P0_IRQ_A, IDX_P0_IRQ_B, IDX_P1_IRQ_A, IDX_P1_IRQ_B});
  assign we_p0r = wr_go && wr_ok && w_lane && (wr_idx == IDX_P0_RISE);
  assign we_p1r = wr_go && wr_ok && w_lane && (wr_idx == IDX_P1_RISE);
  assign we_p0f = wr_go && wr_ok && w_lane && (wr_idx == IDX_P0_FALL);
  assign we_p1f = wr_go && wr_ok && w_lane && (wr_idx == IDX_P1_FALL);
  assign we_cfg = wr_go && wr_ok && w_lane && (wr_idx == IDX_WAKE_CFG);
  assign we_p0a = wr_go && wr_ok && w_lane && (wr_idx == IDX_P0_IRQ_A);
  assign we_p0b = wr_go && wr_ok && w_lane && (wr_idx == IDX_P0_IRQ_B);
  assign we_p1a = wr_go && wr_ok && w_lane && (wr_idx == IDX_P1_IRQ_A);
  assign we_p1b = wr_go && wr_ok && w_lane && (wr_idx == IDX_P1_IRQ_B);
  // Writing a zero enable bit clears the matching status bit
  assign rise_clr = {{8{we_p1r}} & ~w_byte, {8{we_p0r}} & ~w_byte};
  assign fall_clr = {{8{we_p1f}} & ~w_byte, {8{we_p0f}} & ~w_byte};
  ////////////////////////////////////////////////////////////////////////////
  // Edge enables and interrupt routing
  // Writes land only in enable and routing bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_en <= PIN_RESET;
      fall_en <= PIN_RESET;
      irq_a_sel <= PIN_RESET;
      irq_b_sel <= PIN_RESET;
    end else begin
      if (we_p0r) rise_en[7:0] <= w_byte;
      if (we_p1r) rise_en[15:8] <= w_byte;
      if (we_p0f) fall_en[7:0] <= w_byte;
      if (we_p1f) fall_en[15:8] <= w_byte;
      if (we_p0a) irq_a_sel[7:0] <= w_byte;
      if (we_p1a) irq_a_sel[15:8] <= w_byte;
      if (we_p0b) irq_b_sel[7:0] <= w_byte;
      if (we_p1b) irq_b_sel[15:8] <= w_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky edge status; a new edge wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_status <= PIN_RESET;
      fall_status <= PIN_RESET;
    end else begin
      rise_status <= (rise_status & ~rise_clr) | (rise_evt & rise_en);
      fall_status <= (fall_status & ~fall_clr) | (fall_evt & fall_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin interrupts and wake output
  assign next_irq_a = |((rise_status | fall_status) & irq_a_sel);
  assign next_irq_b = |((rise_status | fall_status) & irq_b_sel);
  // Any enabled edge interrupt or wake flag wakes the CPU
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_irq_a <= 1'b0;
      pin_irq_b <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      pin_irq_a <= next_irq_a;
      pin_irq_b <= next_irq_b;
      wake_out <= next_irq_a || next_irq_b || wake_rise_flag || wake_fall_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtered wake-up path
  // Wake configuration; flags cleared by writing a zero enable, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_rise_enable <= 1'b0;
      wake_fall_enable <= 1'b0;
      filter_time_sel <= 2'h0;
      wake_source_sel <= 4'h0;
      wake_rise_flag <= 1'b0;
      wake_fall_flag <= 1'b0;
    end else begin
      if (we_cfg) begin
        wake_rise_enable <= w_byte[CFG_RISE_BIT];
        wake_fall_enable <= w_byte[CFG_FALL_BIT];
        filter_time_sel <= w_byte[CFG_FLT_LSB +: 2];
        wake_source_sel <= w_byte[CFG_SRC_LSB +: 4];
      end
      if (wif.rise_trig) begin
        wake_rise_flag <= 1'b1;
      end else if (we_cfg && !w_byte[CFG_RISE_BIT]) begin
        wake_rise_flag <= 1'b0;
      end
      if (wif.fall_trig) begin
        wake_fall_flag <= 1'b1;
      end else if (we_cfg && !w_byte[CFG_FALL_BIT]) begin
        wake_fall_flag <= 1'b0;
      end
    end
  end

  // Codes 0..7 pick port 0, 8..15 pick port 1
  assign wif.level = stable[wake_source_sel];
  assign wif.rise_en = wake_rise_enable;
  assign wif.fall_en = wake_fall_enable;
  assign wif.flt_sel = filter_time_sel;
  gew_wake_filter #(
    .BASE_CYC(FILT_BASE_CYC)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .wif(wif.filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels
  assign rd_idx = s_axi_araddr[19:2];
  // Reads show status and flags where writes hold enables
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(rd_idx));
    unique case (rd_idx)
      IDX_P0_RISE: rd_word[7:0] = rise_status[7:0];
      IDX_P1_RISE: rd_word[7:0] = rise_status[15:8];
      IDX_P0_FALL: rd_word[7:0] = fall_status[7:0];
      IDX_P1_FALL: rd_word[7:0] = fall_status[15:8];
      IDX_WAKE_CFG: rd_word[7:0] = {wake_rise_flag, wake_fall_flag, filter_time_sel, wake_source_sel};
      IDX_P0_IRQ_A: rd_word[7:0] = irq_a_sel[7:0];
      IDX_P0_IRQ_B: rd_word[7:0] = irq_b_sel[7:0];
      IDX_P1_IRQ_A: rd_word[7:0] = irq_a_sel[15:8];
      IDX_P1_IRQ_B: rd_word[7:0] = irq_b_sel[15:8];
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_RISE_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise_evt[0] && rise_en[0]) |=> rise_status[0])
    else $error("Enabled rising edge did not set status");
  AST_RISE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise_status[0] && !rise_clr[0]) |=> rise_status[0])
    else $error("Rising status lost without clear");
  AST_FALL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_evt[12] && fall_en[12]) |=> fall_status[12])
    else $error("Enabled falling edge did not set status");
  AST_FALL_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    (fall_clr[3] && !fall_evt[3]) |=> !fall_status[3])
    else $error("Falling status not cleared by zero enable write");
  AST_NO_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rise_status[3] && !(rise_evt[3] && rise_en[3])) |=> !rise_status[3])
    else $error("Rising status set without enabled edge");
  AST_IRQ_A: assert property (@(posedge aclk) disable iff (!aresetn)
    |((rise_status | fall_status) & irq_a_sel) |=> pin_irq_a)
    else $error("Interrupt A missing for routed status");
  AST_IRQ_B: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_irq_b |-> |$past((rise_status | fall_status) & irq_b_sel))
    else $error("Interrupt B without routed status");
  AST_WAKE_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_irq_a || pin_irq_b) |-> wake_out)
    else $error("Edge interrupt without wake");
  AST_WFLAG_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
    wif.rise_trig |=> wake_rise_flag ##1 wake_out)
    else $error("Rising wake trigger lost");
  AST_WFLAG_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
    (wake_fall_flag && !(we_cfg && !w_byte[CFG_FALL_BIT])) |=> wake_fall_flag)
    else $error("Falling wake flag dropped without clear");
  AST_RESET_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (rise_en == PIN_RESET) && (fall_en == PIN_RESET) && !wake_rise_flag
      && !wake_fall_flag && (wake_source_sel == 4'h0) && (rise_status == PIN_RESET))
    else $error("Register not zero after reset");
endmodule : gew_edge_wake

// ==== hdl/gew_pkg.sv ====
// Package: register map, field layout, reset values and timing constants
package gew_pkg;
  // Register indices; byte address is four times the index
  localparam logic [17:0] IDX_P0_RISE = 18'h0A028;
  localparam logic [17:0] IDX_P1_RISE = 18'h0A029;
  localparam logic [17:0] IDX_WAKE_CFG = 18'h0A02E;
  localparam logic [17:0] IDX_P0_FALL = 18'h0A038;
  localparam logic [17:0] IDX_P1_FALL = 18'h0A039;
  localparam logic [17:0] IDX_P0_IRQ_A = 18'h0A040;
  localparam logic [17:0] IDX_P0_IRQ_B = 18'h0A041;
  localparam logic [17:0] IDX_P1_IRQ_A = 18'h0A042;
  localparam logic [17:0] IDX_P1_IRQ_B = 18'h0A043;
  // Wake configuration field positions
  localparam int CFG_RISE_BIT = 7;
  localparam int CFG_FALL_BIT = 6;
  localparam int CFG_FLT_LSB = 4;
  localparam int CFG_SRC_LSB = 0;
  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] PIN_RESET = 16'h0000;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing: clock rate and shortest filter time
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int FILT_BASE_MS = 1;
  localparam int FILT_BASE_CYC = FILT_BASE_MS * CLK_FREQ_KHZ;
  localparam int FILT_CNT_W = 20;
endpackage : gew_pkg

// ==== hdl/gew_wake_if.sv ====
// Interface between the register block and the wake-up noise filter
interface gew_wake_if;
  logic level;
  logic rise_en;
  logic fall_en;
  logic [1:0] flt_sel;
  logic rise_trig;
  logic fall_trig;
  modport ctrl (output level, output rise_en, output fall_en, output flt_sel, input rise_trig, input fall_trig);
  modport filt (input level, input rise_en, input fall_en, input flt_sel, output rise_trig, output fall_trig);
endinterface : gew_wake_if

// ==== hdl/gew_wake_filter.sv ====
// Wake-up noise filter and edge trigger for the selected pin
module gew_wake_filter #(
  parameter int BASE_CYC = gew_pkg::FILT_BASE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Wake path
  gew_wake_if.filt wif
);
  import gew_pkg::*;

  logic flt_lvl;
  logic [FILT_CNT_W-1:0] cnt;
  logic [FILT_CNT_W-1:0] limit;

  // Shortest accepted pulse: base time times 1, 2, 4 or 8
  assign limit = FILT_CNT_W'(BASE_CYC) << wif.flt_sel;

  // Level must differ for the full limit before it is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_lvl <= 1'b0;
      cnt <= '0;
      wif.rise_trig <= 1'b0;
      wif.fall_trig <= 1'b0;
    end else begin
      wif.rise_trig <= 1'b0;
      wif.fall_trig <= 1'b0;
      if (wif.level == flt_lvl) begin
        cnt <= '0;
      end else if (cnt == limit - FILT_CNT_W'(1)) begin
        cnt <= '0;
        flt_lvl <= wif.level;
        wif.rise_trig <= wif.level & wif.rise_en;
        wif.fall_trig <= !wif.level & wif.fall_en;
      end else begin
        cnt <= cnt + FILT_CNT_W'(1);
      end
    end
  end

  AST_FILT_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (wif.rise_trig || wif.fall_trig) |-> $past(cnt) == $past(limit) - FILT_CNT_W'(1))
    else $error("Wake trigger without full filter time");
  AST_FILT_STEADY: assert property (@(posedge aclk) disable iff (!aresetn)
    (wif.level == flt_lvl) |=> (cnt == '0) && !wif.rise_trig && !wif.fall_trig)
    else $error("Filter counted while input matched filtered level");
  AST_FILT_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
    wif.rise_trig |-> flt_lvl && $past(wif.rise_en))
    else $error("Rising trigger without enable or high level");
endmodule : gew_wake_filter

// ==== testbench/gew_pin_model.sv ====
// Model of the external levels on the sixteen port pins
module gew_pin_model (
  // Clock
  input wire logic aclk,
  // Pin levels of port 0 and port 1
  output logic [7:0] port0_in,
  output logic [7:0] port1_in
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////
  // Pins start low; a pin holds its level until told otherwise
  initial begin
    port0_in = 8'h00;
    port1_in = 8'h00;
  end

  // Set pin i (0..15) to a level just after the next rising edge
  task automatic set_pin(input int i, input logic v);
    @(posedge aclk);
    if (i < 8) port0_in[i] <= v;
    else port1_in[i-8] <= v;
  endtask : set_pin

  // Drive pin i high for n cycles, then low again
  task automatic pulse(input int i, input int n);
    set_pin(i, 1'b1);
    repeat (n - 1) @(posedge aclk);
    set_pin(i, 1'b0);
  endtask : pulse
endmodule : gew_pin_model

// ==== testbench/tb_top.sv ====
// Testbench: register access, pin edge status, pin interrupts and filtered wake-up
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gew_pkg::*;

  // Short filter base keeps the wake tests brief
  localparam int BASE = 4;
  localparam logic [19:0] A_P0R = {IDX_P0_RISE, 2'h0};
  localparam logic [19:0] A_P1R = {IDX_P1_RISE, 2'h0};
  localparam logic [19:0] A_CFG = {IDX_WAKE_CFG, 2'h0};
  localparam logic [19:0] A_P0F = {IDX_P0_FALL, 2'h0};
  localparam logic [19:0] A_P1F = {IDX_P1_FALL, 2'h0};
  localparam logic [19:0] A_P0A = {IDX_P0_IRQ_A, 2'h0};
  localparam logic [19:0] A_P0B = {IDX_P0_IRQ_B, 2'h0};
  localparam logic [19:0] A_P1A = {IDX_P1_IRQ_A, 2'h0};
  localparam logic [19:0] A_P1B = {IDX_P1_IRQ_B, 2'h0};

  typedef struct {logic [19:0] a; int pin; logic rise; logic [7:0] st;} gew_row_t;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] port0_in;
  logic [7:0] port1_in;
  logic pin_irq_a;
  logic pin_irq_b;
  logic wake_out;
  logic [19:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [19:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  logic [3:0] src;
  logic [1:0] fs;
  int lim;
  int srcs [4] = '{0, 7, 8, 15};
  logic [19:0] regs [9] = '{A_P0R, A_P1R, A_CFG, A_P0F, A_P1F, A_P0A, A_P0B, A_P1A, A_P1B};
  gew_row_t rows [4] = '{'{A_P0R, 0, 1'b1, 8'h01}, '{A_P0F, 3, 1'b0, 8'h08},
                         '{A_P1R, 13, 1'b1, 8'h20}, '{A_P1F, 12, 1'b0, 8'h10}};

  ////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  always #12.5 aclk = ~aclk;

  gew_edge_wake #(.ADDR_W(20), .FILT_BASE_CYC(BASE)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .port0_in(port0_in), .port1_in(port1_in),
    .pin_irq_a(pin_irq_a), .pin_irq_b(pin_irq_b), .wake_out(wake_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  gew_pin_model pm_u (.aclk(aclk), .port0_in(port0_in), .port1_in(port1_in));

  ////////////////////////////////////////////////////////////////////////
  // Compare one result and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // AXI4-Lite write; each channel held until its own ready
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && !awvalid && !wvalid));
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // AXI4-Lite read with expected byte and response
  task automatic rd(input logic [19:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && !arvalid));
    chk(rdata, {24'h0, ed});
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  // Cuts a hang short
  initial begin
    #500us;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    do_reset();
    chk(32'({pin_irq_a, pin_irq_b, wake_out}), 32'h0);
    foreach (regs[i]) rd(regs[i], REG_RESET, RESP_OKAY);
    $display("test reset values done");
    // Edge rows: arm one pin, make the edge, check sticky status and clear
    foreach (rows[i]) begin
      pm_u.set_pin(rows[i].pin, !rows[i].rise);
      cyc(8);
      wr(rows[i].a, rows[i].st, 4'hF, RESP_OKAY);
      pm_u.set_pin(rows[i].pin, rows[i].rise);
      cyc(8);
      rd(rows[i].a, rows[i].st, RESP_OKAY);
      chk(32'({pin_irq_a, pin_irq_b, wake_out}), 32'h0);
      pm_u.set_pin(rows[i].pin, !rows[i].rise);
      cyc(20);
      rd(rows[i].a, rows[i].st, RESP_OKAY);
      wr(rows[i].a, 8'h00, 4'hF, RESP_OKAY);
      rd(rows[i].a, 8'h00, RESP_OKAY);
    end
    $display("test edge rows done");
    // Routing: pin 0 to both lines, pin 10 to line B only
    wr(A_P0A, 8'h01, 4'hF, RESP_OKAY);
    wr(A_P0B, 8'h01, 4'hF, RESP_OKAY);
    wr(A_P1B, 8'h04, 4'hF, RESP_OKAY);
    wr(A_P0R, 8'h01, 4'hF, RESP_OKAY);
    wr(A_P1R, 8'h04, 4'hF, RESP_OKAY);
    pm_u.set_pin(0, 1'b1);
    cyc(8);
    chk(32'({pin_irq_a, pin_irq_b, wake_out}), 32'h7);
    wr(A_P0R, 8'h00, 4'hF, RESP_OKAY);
    cyc(3);
    chk(32'({pin_irq_a, pin_irq_b, wake_out}), 32'h0);
    pm_u.set_pin(10, 1'b1);
    cyc(8);
    chk(32'({pin_irq_a, pin_irq_b, wake_out}), 32'h3);
    rd(A_P1B, 8'h04, RESP_OKAY);
    wr(A_P1R, 8'h00, 4'hF, RESP_OKAY);
    wr(A_P1B, 8'h00, 4'h0, RESP_OKAY);
    rd(A_P1B, 8'h04, RESP_OKAY);
    pm_u.set_pin(0, 1'b0);
    cyc(8);
    rd(A_P0F, 8'h00, RESP_OKAY);
    $display("test routing done");
    // Filtered wake-up for each filter setting and a spread of sources
    for (int k = 0; k < 4; k++) begin
      src = srcs[k][3:0];
      fs = k[1:0];
      lim = BASE << k;
      wr(A_CFG, {2'b10, fs, src}, 4'hF, RESP_OKAY);
      pm_u.pulse(src, lim - 2);
      cyc(lim + 8);
      rd(A_CFG, {2'b00, fs, src}, RESP_OKAY);
      pm_u.pulse({src[3:1], ~src[0]}, lim + 8);
      cyc(lim + 8);
      rd(A_CFG, {2'b00, fs, src}, RESP_OKAY);
      pm_u.set_pin(src, 1'b1);
      cyc(lim + 8);
      rd(A_CFG, {2'b10, fs, src}, RESP_OKAY);
      chk(32'(wake_out), 32'h1);
      wr(A_CFG, {2'b01, fs, src}, 4'hF, RESP_OKAY);
      pm_u.set_pin(src, 1'b0);
      cyc(lim + 8);
      rd(A_CFG, {2'b01, fs, src}, RESP_OKAY);
      wr(A_CFG, 8'h00, 4'hF, RESP_OKAY);
      rd(A_CFG, 8'h00, RESP_OKAY);
    end
    // Both edge enables: a rise and then a fall each set their own flag
    wr(A_CFG, 8'hC7, 4'hF, RESP_OKAY);
    pm_u.set_pin(7, 1'b1);
    cyc(BASE + 8);
    pm_u.set_pin(7, 1'b0);
    cyc(BASE + 8);
    rd(A_CFG, 8'hC7, RESP_OKAY);
    wr(A_CFG, 8'h00, 4'hF, RESP_OKAY);
    $display("test wake filter done");
    // Unmapped and misaligned places, then a reset in mid-run
    wr(20'h00010, 8'hFF, 4'hF, RESP_SLVERR);
    rd(20'h00010, 8'h00, RESP_SLVERR);
    rd(A_P0R + 20'h1, 8'h00, RESP_SLVERR);
    wr(A_P0A, 8'h55, 4'hF, RESP_OKAY);
    do_reset();
    rd(A_P0A, REG_RESET, RESP_OKAY);
    $display("test errors and reset done");
    report_and_stop();
  end
endmodule : tb_top
